/* logic/rsbc_top.sv */
// Reset source tracking, pin filtering and brown-out sequencing behind an APB slave.
`timescale 1ns/1ps

// Functional notes
// RL1: Eight reset causes are told apart: por, pin run, pin sleep, wdt, bor, instr, stack full, stack underflow.
// RL2: Low five bits of reset_control_status are per-cause event flags.
// RL3: Hardware clears flags on events; software sets them again afterwards. Software here cannot write to_q or pdown_q; hardware sets those.
// RL4: Bit 7 is read/write priority_levels_on, reset to zero.
// RL5: soft_brownout_on enables brown-out only in config 01; else reads zero.
// RL6: Power-on clears power_on_flag; no other reset touches it.
// RL7: Nothing in hardware sets power_on_flag; software writes it to one.
// RL8: While brown-out enabled, brown-out or power-on clears brownout_flag.
// RL9: Software sees brown-out as brownout_flag zero with power_on_flag one.
// RL10: A low external_reset_pin resets the device.
// RL11: Short low pulses on external_reset_pin are filtered out.
// RL12: Internal resets never drive external_reset_pin low.
// RL13: With ext_reset_pin_on clear, the pin is only a digital input.
// RL14: Supply rising past threshold gives a power-on reset pulse.
// RL15: Supply below threshold longer than minimum duration causes brown-out reset.
// RL16: Brown-out reset holds while supply stays below threshold.
// RL17: Enabled power-up timer adds one delay after supply recovers.
// RL18: Supply dipping while timer counts returns to brown-out and restarts timer.
// RL19: Brown-out enable and power-up timer enable are independent.
// RL20: Trip level comes only from brownout_level_select, never from software.
// RL21: Config 10 disables brown-out during sleep, re-enables on leaving it.
// RL22: Config 00 always off, 11 always on; soft bit unavailable in both.
// RL23: Power-up timer is 11-bit, counts 2048 low-frequency oscillator periods.
// RL24: Instruction, watchdog and sleep events clear their flags; power-up sets three.
// RL25: Bit 5 reads zero and ignores writes.
module rsbc_top import rsbc_pkg::*; (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External reset pin, input only.
  input wire logic external_reset_pin,
  output logic pin_digital_in,
  // Supply monitor inputs and configuration.
  input wire logic power_on_pulse,
  input wire logic supply_below_bor,
  input wire logic [1:0] brownout_config,
  input wire logic [1:0] brownout_level_select,
  input wire logic ext_reset_pin_on,
  input wire logic powerup_timer_on,
  // Core events and mode.
  input wire logic reset_instr_exec,
  input wire logic watchdog_timeout,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_exec,
  input wire logic in_sleep,
  input wire logic stack_full_reset,
  input wire logic stack_underflow_reset,
  // Reset outputs.
  output logic system_reset,
  output logic [2:0] reset_cause,
  output logic [1:0] brownout_level,
  output logic brownout_armed
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for every asynchronous input.
  localparam int NS = 12;
  logic [NS-1:0] raw_in, s1_q, s2_q;
  assign raw_in = {external_reset_pin, power_on_pulse, supply_below_bor, reset_instr_exec,
                   watchdog_timeout, watchdog_clear_instr, sleep_exec, in_sleep,
                   stack_full_reset, stack_underflow_reset, ext_reset_pin_on, powerup_timer_on};

  // Two stages; the first stage is read only by the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {1'b1, {(NS - 1){1'b0}}};
      s2_q <= {1'b1, {(NS - 1){1'b0}}};
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end

  logic pin_s, por_s, low_s, rinst_s, wdt_s, wdclr_s, slp_s, insleep_s, stkf_s, stku_s;
  logic pin_on_s, pud_on_s;
  assign {pin_s, por_s, low_s, rinst_s, wdt_s, wdclr_s, slp_s, insleep_s, stkf_s, stku_s,
          pin_on_s, pud_on_s} = s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin path: glitch filter, then qualified by the enable.
  logic pin_f, low_f;

  // A disabled pin feeds the filter its idle level, so re-enabling it cannot
  // fire a reset from a low level that was seen while it was a plain input.
  logic pin_gated;
  assign pin_gated = pin_s | ~pin_on_s;

  rsbc_filter #(.CYCLES(RSBC_FILT_CYCLES), .INIT(1'b1)) u_pin_filt ( // see RL11
    .pclk(pclk),
    .presetn(presetn),
    .din(pin_gated),
    .dout(pin_f)
  );

  // Supply must stay low for the minimum duration before it counts.
  rsbc_filter #(.CYCLES(RSBC_BOR_CYCLES), .INIT(1'b0)) u_bor_filt ( // see RL15
    .pclk(pclk),
    .presetn(presetn),
    .din(low_s),
    .dout(low_f)
  );

  logic pin_reset;
  assign pin_reset = pin_on_s & ~pin_f; // see RL10 see RL13

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic prio_q, soft_en_q, rinst_q, to_q, pdown_q, por_q, bor_q;
  logic [2:0] cause_q;
  logic bor_en;

  // The soft enable only matters in the software configuration.
  assign bor_en = (brownout_config == RSBC_BOR_SOFT) ? soft_en_q : // see RL5
                  (brownout_config == RSBC_BOR_NOSLEEP) ? ~insleep_s : // see RL21
                  (brownout_config == RSBC_BOR_ON); // see RL22 see RL19

  logic wr_rcs;
  assign wr_rcs = psel & penable & pwrite & (paddr == RSBC_RCS_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Power-up delay prescaler: one enable pulse per low-frequency period.
  localparam int DW = $clog2(RSBC_LF_DIV);
  logic [DW-1:0] div_q;
  logic lf_tick;
  assign lf_tick = (div_q == DW'(RSBC_LF_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (lf_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out sequencer; power-on also runs the delay.
  rsbc_seq_t seq_q;
  logic [RSBC_PUD_WIDTH-1:0] pud_q;
  logic bor_trip;
  // The filter also delays the release, so the raw level must still be low;
  // otherwise a recovered supply would keep tripping for the filter length.
  assign bor_trip = bor_en & low_f & low_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= RSBC_BOR_HOLD;
      pud_q <= '0;
    end else begin
      case (seq_q)
        RSBC_RUN: begin
          if (por_s || bor_trip) begin // see RL14 see RL15
            seq_q <= RSBC_BOR_HOLD;
          end
        end
        RSBC_BOR_HOLD: begin
          pud_q <= '0; // see RL18
          if (!por_s && !(bor_en && low_s)) begin // see RL16
            seq_q <= pud_on_s ? RSBC_PUD_WAIT : RSBC_RUN; // see RL17
          end
        end
        RSBC_PUD_WAIT: begin
          if (por_s || (bor_en && low_s)) begin
            seq_q <= RSBC_BOR_HOLD; // see RL18
          end else if (lf_tick) begin
            pud_q <= pud_q + RSBC_PUD_WIDTH'(1); // see RL23
            if (pud_q == RSBC_PUD_WIDTH'(RSBC_PUD_CYCLES - 1)) begin
              seq_q <= RSBC_RUN;
            end
          end
        end
        default: seq_q <= RSBC_BOR_HOLD;
      endcase
    end
  end

  // Power-on and brown-out reset events. Events override a same-cycle software write.
  logic ev_por, ev_bor;
  assign ev_por = por_s;
  assign ev_bor = bor_trip & (seq_q == RSBC_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Control bits: priority and soft brown-out enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_q <= RSBC_RCS_RESET[RSBC_BIT_PRIO];
      soft_en_q <= RSBC_RCS_RESET[RSBC_BIT_SOFT_BOR];
    end else if (ev_por) begin
      prio_q <= 1'b0;
      soft_en_q <= 1'b1;
    end else if (wr_rcs) begin
      prio_q <= pwdata[RSBC_BIT_PRIO]; // see RL4
      if (brownout_config == RSBC_BOR_SOFT) begin
        soft_en_q <= pwdata[RSBC_BIT_SOFT_BOR]; // see RL5
      end
    end
  end

  // Cause flags: software may write only rinst_q, hardware clears them and wins. See RL3.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rinst_q <= RSBC_RCS_RESET[RSBC_BIT_RESET_INSTR];
      to_q <= RSBC_RCS_RESET[RSBC_BIT_WDOG];
      pdown_q <= RSBC_RCS_RESET[RSBC_BIT_POWERDOWN];
    end else begin
      if (ev_por || ev_bor) begin
        rinst_q <= 1'b1;
      end else if (rinst_s) begin
        rinst_q <= 1'b0; // see RL24
      end else if (wr_rcs) begin
        rinst_q <= pwdata[RSBC_BIT_RESET_INSTR]; // see RL3
      end
      if (wdt_s) begin
        to_q <= 1'b0; // see RL24
      end else if (ev_por || ev_bor || wdclr_s || slp_s || (pin_reset && insleep_s)) begin
        to_q <= 1'b1;
      end
      if (slp_s || (pin_reset && insleep_s)) begin
        pdown_q <= 1'b0; // see RL24
      end else if (ev_por || ev_bor || wdclr_s) begin
        pdown_q <= 1'b1;
      end
    end
  end

  // Power-on and brown-out flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_q <= RSBC_RCS_RESET[RSBC_BIT_POWER_ON];
      bor_q <= RSBC_RCS_RESET[RSBC_BIT_BROWNOUT];
    end else begin
      if (ev_por) begin
        por_q <= 1'b0; // see RL6
      end else if (wr_rcs && pwdata[RSBC_BIT_POWER_ON]) begin
        por_q <= 1'b1; // see RL7
      end
      if (ev_bor || (ev_por && bor_en)) begin
        bor_q <= 1'b0; // see RL8
      end else if (wr_rcs) begin
        bor_q <= pwdata[RSBC_BIT_BROWNOUT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined reset output and last cause code: 1 por, 2 pin run, 3 pin sleep,
  // 4 wdt, 5 bor, 6 instr, 7 stack full, 0 stack underflow.
  logic any_reset;
  assign any_reset = (seq_q != RSBC_RUN) | pin_reset | rinst_s | (wdt_s & ~insleep_s) |
                     stkf_s | stku_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset <= 1'b1;
      cause_q <= 3'h1;
    end else begin
      system_reset <= any_reset; // see RL12
      if (ev_por) cause_q <= 3'h1; // see RL1
      else if (ev_bor) cause_q <= 3'h5;
      else if (pin_reset) cause_q <= insleep_s ? 3'h3 : 3'h2;
      else if (wdt_s && !insleep_s) cause_q <= 3'h4;
      else if (rinst_s) cause_q <= 3'h6;
      else if (stkf_s) cause_q <= 3'h7;
      else if (stku_s) cause_q <= 3'h0;
    end
  end

  // Status outputs, registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_digital_in <= 1'b1;
      brownout_level <= 2'h0;
      brownout_armed <= 1'b0;
    end else begin
      pin_digital_in <= pin_on_s ? 1'b1 : pin_s; // see RL13
      brownout_level <= brownout_level_select; // see RL20
      brownout_armed <= bor_en;
    end
  end
  assign reset_cause = cause_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states; unmapped addresses error and read zero.
  logic [7:0] rcs_view;
  assign rcs_view = {prio_q, (brownout_config == RSBC_BOR_SOFT) & soft_en_q, 1'b0, // see RL25
                     rinst_q, to_q, pdown_q, por_q, bor_q}; // see RL2

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        case (paddr)
          RSBC_RCS_OFFSET: prdata <= {24'h0, rcs_view};
          RSBC_CFG_OFFSET: prdata <= {26'h0, brownout_level_select, brownout_config, pin_on_s,
                                      pud_on_s};
          RSBC_STAT_OFFSET: prdata <= {27'h0, cause_q, seq_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_por_clears_flag: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
    ev_por |=> !por_q) else $error("power-on did not clear flag");
  a_por_no_hw_set: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    (!por_q && !wr_rcs) |=> !por_q) else $error("power-on flag set by hardware");
  a_bor_clears_flag: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
    ev_bor |=> !bor_q) else $error("brown-out did not clear flag");
  a_soft_bit_reads: assert property (@(posedge pclk) disable iff (!presetn) // see RL5
    (psel && !penable && paddr == RSBC_RCS_OFFSET && brownout_config != RSBC_BOR_SOFT)
    |=> !prdata[RSBC_BIT_SOFT_BOR]) else $error("soft bit visible");
  a_bit5_zero: assert property (@(posedge pclk) disable iff (!presetn) // see RL25
    (psel && !penable && paddr == RSBC_RCS_OFFSET) |=> !prdata[5])
    else $error("bit five not zero");
  a_bor_holds: assert property (@(posedge pclk) disable iff (!presetn) // see RL16
    (seq_q == RSBC_BOR_HOLD && bor_en && low_s) |=> seq_q == RSBC_BOR_HOLD)
    else $error("left brown-out hold early");
  a_dip_restarts: assert property (@(posedge pclk) disable iff (!presetn) // see RL18
    (seq_q == RSBC_PUD_WAIT && bor_en && low_s) |=> ##1 pud_q == '0)
    else $error("timer not restarted");
  a_cfg_off: assert property (@(posedge pclk) disable iff (!presetn) // see RL22
    brownout_config == RSBC_BOR_OFF |=> !brownout_armed) else $error("brown-out on in off mode");
  a_reset_follows: assert property (@(posedge pclk) disable iff (!presetn) // see RL10
    pin_reset |=> system_reset) else $error("pin reset not applied");

endmodule : rsbc_top

/* logic/rsbc_pkg.sv */
// Package with register map, reset values and timing constants for the reset source block.
package rsbc_pkg;

  // Register map (byte addresses on APB).
  localparam logic [11:0] RSBC_RCS_OFFSET = 12'h000;
  localparam logic [11:0] RSBC_CFG_OFFSET = 12'h004;
  localparam logic [11:0] RSBC_STAT_OFFSET = 12'h008;

  // Field positions in reset_control_status.
  localparam int RSBC_BIT_BROWNOUT = 0;
  localparam int RSBC_BIT_POWER_ON = 1;
  localparam int RSBC_BIT_POWERDOWN = 2;
  localparam int RSBC_BIT_WDOG = 3;
  localparam int RSBC_BIT_RESET_INSTR = 4;
  localparam int RSBC_BIT_SOFT_BOR = 6;
  localparam int RSBC_BIT_PRIO = 7;

  // Brown-out configurations.
  localparam logic [1:0] RSBC_BOR_OFF = 2'h0;
  localparam logic [1:0] RSBC_BOR_SOFT = 2'h1;
  localparam logic [1:0] RSBC_BOR_NOSLEEP = 2'h2;
  localparam logic [1:0] RSBC_BOR_ON = 2'h3;

  // Values after power-on reset.
  localparam logic [7:0] RSBC_RCS_RESET = 8'h5c;

  // Timing: low-frequency oscillator period and glitch filter length.
  localparam int RSBC_LFOSC_PERIOD_NS = 32000;
  localparam int RSBC_CLK_PERIOD_NS = 5;
  localparam int RSBC_LF_DIV = RSBC_LFOSC_PERIOD_NS / RSBC_CLK_PERIOD_NS;
  localparam int RSBC_PUD_CYCLES = 2048;
  localparam int RSBC_PUD_WIDTH = 11;
  localparam int RSBC_FILT_NS = 100;
  localparam int RSBC_FILT_CYCLES = (RSBC_FILT_NS + RSBC_CLK_PERIOD_NS - 1) / RSBC_CLK_PERIOD_NS;
  localparam int RSBC_BOR_MIN_NS = 200;
  localparam int RSBC_BOR_CYCLES = (RSBC_BOR_MIN_NS + RSBC_CLK_PERIOD_NS - 1) / RSBC_CLK_PERIOD_NS;

  // Sequencer states.
  typedef enum logic [1:0] {RSBC_RUN, RSBC_BOR_HOLD, RSBC_PUD_WAIT} rsbc_seq_t;

endpackage : rsbc_pkg

/* logic/rsbc_filter.sv */
// Persistence filter: the output follows the input only after it held steady for a count.
`timescale 1ns/1ps
module rsbc_filter #(
  parameter int CYCLES = 4,
  parameter logic INIT = 1'b0
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Raw level and filtered level.
  input wire logic din,
  output logic dout
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CMAX = CW'(CYCLES);
  logic [CW-1:0] cnt_q;

  // Count while the input differs from the output; a short pulse resets the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (din == dout) begin
      cnt_q <= '0;
    end else if (cnt_q != CMAX) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Take the new level only once it has persisted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= INIT;
    end else if (din != dout && cnt_q == CMAX) begin
      dout <= din;
    end
  end

endmodule : rsbc_filter

/* bench/rsbc_partner.sv */
// Behavioural model of the reset pin driver and the supply monitors.
`timescale 1ns/1ps
module rsbc_partner (
  // Clock.
  input wire logic pclk,
  // Pin and supply levels.
  output logic external_reset_pin,
  output logic power_on_pulse,
  output logic supply_below_bor
);
  // The pin idles high through its pull-up, and the supply starts good.
  initial begin
    external_reset_pin = 1'b1;
    power_on_pulse = 1'b0;
    supply_below_bor = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Holds one source active for n cycles: 0 pin low, 1 supply dip, else power-on.
  // Called just after a rising edge; all levels return to idle at the end.
  task automatic act(input int which, input int n);
    case (which)
      0: external_reset_pin <= 1'b0;
      1: supply_below_bor <= 1'b1;
      default: power_on_pulse <= 1'b1;
    endcase
    repeat (n) @(posedge pclk);
    external_reset_pin <= 1'b1;
    supply_below_bor <= 1'b0;
    power_on_pulse <= 1'b0;
  endtask : act
endmodule : rsbc_partner

/* bench/test_rsbc_top.sv */
// Self-checking testbench for the reset source and brown-out block.
`timescale 1ns/1ps
module test_rsbc_top;
  import rsbc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic external_reset_pin, pin_digital_in, power_on_pulse, supply_below_bor;
  logic [1:0] brownout_config, brownout_level_select, brownout_level;
  logic ext_reset_pin_on, powerup_timer_on, reset_instr_exec, watchdog_timeout;
  logic watchdog_clear_instr, sleep_exec, in_sleep, stack_full_reset, stack_underflow_reset;
  logic system_reset, brownout_armed;
  logic [2:0] reset_cause;
  logic [2:0] cs [4] = '{3'h6, 3'h4, 3'h7, 3'h0};
  logic [7:0] flg [4] = '{8'h0b, 8'h13, 8'h13, 8'h13};
  int fails = 0;
  int cmp_count = 0;

  // A 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Device and far-side model.
  rsbc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_reset_pin, .pin_digital_in, .power_on_pulse,
    .supply_below_bor, .brownout_config, .brownout_level_select, .ext_reset_pin_on,
    .powerup_timer_on, .reset_instr_exec, .watchdog_timeout, .watchdog_clear_instr,
    .sleep_exec, .in_sleep, .stack_full_reset, .stack_underflow_reset, .system_reset,
    .reset_cause, .brownout_level, .brownout_armed);
  rsbc_partner u_part (.pclk, .external_reset_pin, .power_on_pulse, .supply_below_bor);

  //////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One APB transfer; an idle cycle follows so back-to-back calls never clash.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      check("pready", pready, 1'b1);
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Waits, with a bound, until the held-in-reset output reaches a level.
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (system_reset !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (system_reset !== v) begin
      check("system_reset", system_reset, v);
      wrap_up();
    end
  endtask : wait_rst

  // Pulses one core event for four cycles, longer than the synchroniser needs.
  task automatic ev(input int k);
    case (k)
      0: reset_instr_exec <= 1'b1;
      1: watchdog_timeout <= 1'b1;
      2: stack_full_reset <= 1'b1;
      3: stack_underflow_reset <= 1'b1;
      4: watchdog_clear_instr <= 1'b1;
      default: sleep_exec <= 1'b1;
    endcase
    repeat (4) @(posedge pclk);
    {reset_instr_exec, watchdog_timeout, stack_full_reset} <= 3'h0;
    {stack_underflow_reset, watchdog_clear_instr, sleep_exec} <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask : ev

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence; configuration starts in software-controlled brown-out mode.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {reset_instr_exec, watchdog_timeout, watchdog_clear_instr, sleep_exec} = 4'h0;
    {in_sleep, stack_full_reset, stack_underflow_reset, powerup_timer_on} = 4'h0;
    brownout_config = RSBC_BOR_SOFT;
    brownout_level_select = 2'h2;
    ext_reset_pin_on = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, RSBC_RCS_OFFSET, 0);
    check("rcs reset", rd, 32'h5c);
    apb(0, RSBC_CFG_OFFSET, 0);
    check("cfg view", rd, 32'h26);
    apb(0, 12'h00c, 0);
    check("unmapped err", err, 1'b1);
    wait_rst(0);
    check("por cause", 32'(reset_cause), 32'h1);
    check("level", 32'(brownout_level), 32'h2);
    $display("test reset done");
    apb(1, RSBC_RCS_OFFSET, 32'hff);
    apb(0, RSBC_RCS_OFFSET, 0);
    check("rcs write", rd, 32'hdf);
    check("armed soft1", brownout_armed, 1'b1);
    apb(1, RSBC_RCS_OFFSET, 32'h9f);
    apb(0, RSBC_RCS_OFFSET, 0);
    check("soft clear", rd, 32'h9f);
    check("armed soft0", brownout_armed, 1'b0);
    u_part.act(1, 100);
    check("no bor soft0", system_reset, 1'b0);
    apb(1, RSBC_RCS_OFFSET, 32'hdf);
    apb(1, RSBC_CFG_OFFSET, 0);
    apb(0, RSBC_CFG_OFFSET, 0);
    check("cfg ro", rd, 32'h26);
    check("level kept", 32'(brownout_level), 32'h2);
    $display("test register done");
    fork
      u_part.act(1, 200);
      begin
        repeat (150) @(posedge pclk);
        check("bor held", system_reset, 1'b1);
      end
    join
    wait_rst(0);
    apb(0, RSBC_RCS_OFFSET, 0);
    check("bor flags", rd & 32'h3, 32'h2);
    check("bor cause", 32'(reset_cause), 32'h5);
    $display("test brownout done");
    u_part.act(0, 5);
    repeat (40) @(posedge pclk);
    check("short pulse", system_reset, 1'b0);
    for (int s = 0; s < 2; s++) begin
      in_sleep <= s[0];
      fork
        u_part.act(0, 60);
        begin
          repeat (50) @(posedge pclk);
          check("pin reset", system_reset, 1'b1);
        end
      join
      wait_rst(0);
      check("pin cause", 32'(reset_cause), 32'(2 + s));
    end
    in_sleep <= 1'b0;
    ext_reset_pin_on <= 1'b0;
    fork
      u_part.act(0, 60);
      begin
        repeat (40) @(posedge pclk);
        check("pin off", system_reset, 1'b0);
        check("pin in", pin_digital_in, 1'b0);
      end
    join
    ext_reset_pin_on <= 1'b1;
    $display("test pin done");
    for (int k = 0; k < 4; k++) begin
      apb(1, RSBC_RCS_OFFSET, 32'hdf);
      ev(k);
      wait_rst(0);
      apb(0, RSBC_RCS_OFFSET, 0);
      check("event flag", rd & 32'h1b, 32'(flg[k]));
      check("event cause", 32'(reset_cause), 32'(cs[k]));
    end
    ev(4);
    apb(0, RSBC_RCS_OFFSET, 0);
    check("watchdog clear flag", rd & 32'h08, 32'h08);
    ev(5);
    apb(0, RSBC_RCS_OFFSET, 0);
    check("sleep clears powerdown", rd & 32'h04, 32'h0);
    $display("test events done");
    apb(1, RSBC_RCS_OFFSET, 32'hdf);
    u_part.act(2, 20);
    wait_rst(0);
    apb(0, RSBC_RCS_OFFSET, 0);
    check("por flags", rd & 32'hc3, 32'h40);
    apb(1, RSBC_RCS_OFFSET, 32'hdf);
    apb(0, RSBC_RCS_OFFSET, 0);
    check("por rearm", rd & 32'h3, 32'h3);
    $display("test poweron done");
    for (int c = 0; c < 4; c++) begin
      brownout_config <= c[1:0];
      apb(1, RSBC_RCS_OFFSET, 32'hdf);
      apb(0, RSBC_RCS_OFFSET, 0);
      check("soft read", rd & 32'h40, (c == 1) ? 32'h40 : 32'h0);
      check("armed cfg", brownout_armed, c != 0);
      if (c == 0) begin
        u_part.act(1, 100);
        check("bor off", system_reset, 1'b0);
        // Let the supply level settle before the next mode arms the detector.
        repeat (50) @(posedge pclk);
      end
      if (c == 2) begin
        in_sleep <= 1'b1;
        repeat (6) @(posedge pclk);
        check("sleep off", brownout_armed, 1'b0);
        in_sleep <= 1'b0;
        repeat (6) @(posedge pclk);
        check("wake on", brownout_armed, 1'b1);
      end
    end
    brownout_config <= RSBC_BOR_SOFT;
    apb(1, RSBC_RCS_OFFSET, 32'hdf);
    $display("test config done");
    powerup_timer_on <= 1'b1;
    u_part.act(1, 100);
    repeat (300) @(posedge pclk);
    check("delay held", system_reset, 1'b1);
    apb(0, RSBC_STAT_OFFSET, 0);
    check("seq delay", rd & 32'h3, 32'h2);
    fork
      u_part.act(1, 100);
      begin
        repeat (60) @(posedge pclk);
        apb(0, RSBC_STAT_OFFSET, 0);
        check("seq back", rd & 32'h3, 32'h1);
      end
    join
    repeat (300) @(posedge pclk);
    apb(0, RSBC_STAT_OFFSET, 0);
    check("seq restart", rd & 32'h3, 32'h2);
    check("restart held", system_reset, 1'b1);
    $display("test timer done");
    wrap_up();
  end
endmodule : test_rsbc_top
